// ---- design/pmg_pair_capture.sv ----
`timescale 1ns/1ns
`default_nettype none
// one microphone interface: clock generator and left/right capture
module pmg_pair_capture (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire pmg_pkg::pmg_ctrl_s ctrl_i,
  input wire logic mic_data_i,
  output logic mic_clk_o,
  output pmg_pkg::pmg_sample_s sample_o
);
  import pmg_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HIGH = 2'b01,
    ST_LOW = 2'b10
  } pmg_clk_state_e;

  pmg_clk_state_e state_ff;
  pmg_clk_state_e nxt_state;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic clk_ff;
  pmg_sample_s sample_ff;
  logic [1:0] half_len;
  wire any_en;
  wire half_done;
  wire rise_evt;
  wire fall_evt;
  wire mid_evt;
  wire take_rise;
  wire take_fall;
  wire rise_is_left;

  // clock starts only when a channel is enabled and stops at the end of a low half once neither is
  assign any_en = ctrl_i.right_en | ctrl_i.left_en;
  assign half_len = ctrl_i.clk_rate ? HALF_DIV8 : HALF_DIV4;
  // at or past the end, so a rate drop mid-half cannot overrun the counter
  assign half_done = (cnt_ff >= half_len);
  // no capture on the rise out of idle: the microphones have not been clocked yet
  assign rise_evt = (state_ff == ST_LOW) && (nxt_state == ST_HIGH);
  assign fall_evt = (state_ff == ST_HIGH) && (nxt_state == ST_LOW);
  // midway point of the current half period
  assign mid_evt = (state_ff != ST_IDLE) && (cnt_ff == (half_len >> 1)) && !half_done;
  // sample at the edge itself or in the middle of the half that follows
  assign take_rise = ctrl_i.sample_phase ? (mid_evt && state_ff == ST_HIGH) : rise_evt;
  assign take_fall = ctrl_i.sample_phase ? (mid_evt && state_ff == ST_LOW) : fall_evt;
  assign rise_is_left = !ctrl_i.data_sel;

  // clock generator state machine
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 2'h1;
    unique case (state_ff)
      ST_IDLE: begin
        nxt_cnt = 2'h0;
        if (any_en) begin
          nxt_state = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (half_done) begin
          nxt_state = ST_LOW;
          nxt_cnt = 2'h0;
        end
      end
      ST_LOW: begin
        if (half_done) begin
          nxt_cnt = 2'h0;
          nxt_state = any_en ? ST_HIGH : ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_cnt = 2'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 2'h0;
      clk_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      clk_ff <= (nxt_state == ST_HIGH);
    end
  end

  // capture into the channel selected by edge polarity
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_ff <= '0;
    end else begin
      sample_ff.left_valid <= ctrl_i.left_en &&
        ((take_rise && rise_is_left) || (take_fall && !rise_is_left));
      sample_ff.right_valid <= ctrl_i.right_en &&
        ((take_rise && !rise_is_left) || (take_fall && rise_is_left));
      if (take_rise || take_fall) begin
        sample_ff.data <= mic_data_i;
      end
    end
  end

  assign mic_clk_o = clk_ff;
  assign sample_o = sample_ff;
endmodule : pmg_pair_capture
`default_nettype wire

// ---- design/pmg_top.sv ----
// Behaviour
// - input gain 7 bits, -83.25 dB, 0.75 dB steps
// - input gain resets 0x6F unity, top +12 dB
// - output gain 8 bits, resets 0x6F unity
// - four input gains at consecutive addresses
// - bit 7 enables right channel capture
// - bit 6 enables left channel capture
// - mic clock divide 4 or 8 by rate
// - phase bit samples on or between edges
// - select bit swaps left and right edges
// - second interface has identical independent controls
`timescale 1ns/1ns
`default_nettype none
module pmg_top (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // microphone interfaces
  input wire logic [1:0] pdm_mic_data_i,
  output logic [1:0] pdm_mic_clock_pin_o,
  output pmg_pkg::pmg_sample_s [1:0] mic_sample_o,
  // gain settings for the signal path
  output pmg_pkg::pmg_gain_s gain_o
);
  import pmg_pkg::*;

  logic rst_meta_ff;
  logic rst_sync_ff;
  logic [7:0] pair_ctrl_ff [2];
  logic [6:0] in_gain_ff [4];
  logic [7:0] out_gain_ff [2];
  logic [31:0] rdata_ff;
  logic err_ff;
  logic [7:0] rd_byte;
  pmg_ctrl_s ctrl [2];
  wire [9:0] idx;
  wire wr_en;
  wire rd_en;
  wire hit_ctrl;
  wire hit_in;
  wire hit_out;
  wire hit_any;
  wire [7:0] wbyte;

  // reset release through two flip-flops
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // apb decode; always ready, access taken in the access phase
  assign idx = paddr_i[11:ADDR_LSB];
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign hit_ctrl = (idx == {2'b00, IDX_PAIR_ONE_CTRL}) || (idx == {2'b00, IDX_PAIR_TWO_CTRL});
  assign hit_in = (idx >= {2'b00, IDX_IN_A_LEFT}) && (idx <= {2'b00, IDX_IN_B_RIGHT});
  assign hit_out = (idx == {2'b00, IDX_OUT_A_LEFT}) || (idx == {2'b00, IDX_OUT_A_RIGHT});
  assign hit_any = hit_ctrl || hit_in || hit_out;
  assign wbyte = pwdata_i[7:0];

  // register file: one storage loop per register group
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ctrl
      always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
          pair_ctrl_ff[gi] <= CTRL_RESET;
        end else if (wr_en && pstrb_i[0] && idx == {2'b00, IDX_PAIR_ONE_CTRL} + 10'(gi)) begin
          pair_ctrl_ff[gi] <= wbyte & CTRL_WMASK;
        end
      end
      assign ctrl[gi].right_en = pair_ctrl_ff[gi][BIT_RIGHT_EN];
      assign ctrl[gi].left_en = pair_ctrl_ff[gi][BIT_LEFT_EN];
      assign ctrl[gi].clk_rate = pair_ctrl_ff[gi][BIT_CLK_RATE];
      assign ctrl[gi].sample_phase = pair_ctrl_ff[gi][BIT_SAMPLE_PHASE];
      assign ctrl[gi].data_sel = pair_ctrl_ff[gi][BIT_DATA_SEL];
      // each interface is an independent instance
      pmg_pair_capture u_pair (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_sync_ff),
        .ctrl_i(ctrl[gi]),
        .mic_data_i(pdm_mic_data_i[gi]),
        .mic_clk_o(pdm_mic_clock_pin_o[gi]),
        .sample_o(mic_sample_o[gi])
      );
    end
    for (gi = 0; gi < 4; gi++) begin : g_in_gain
      always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
          in_gain_ff[gi] <= IN_GAIN_RESET;
        end else if (wr_en && pstrb_i[0] && idx == {2'b00, IDX_IN_A_LEFT} + 10'(gi)) begin
          in_gain_ff[gi] <= wbyte[6:0];
        end
      end
    end
    for (gi = 0; gi < 2; gi++) begin : g_out_gain
      always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
          out_gain_ff[gi] <= OUT_GAIN_RESET;
        end else if (wr_en && pstrb_i[0] && idx == {2'b00, IDX_OUT_A_LEFT} + 10'(gi)) begin
          out_gain_ff[gi] <= wbyte;
        end
      end
    end
  endgenerate

  // read multiplexer; reserved bits read zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      {2'b00, IDX_PAIR_ONE_CTRL}: rd_byte = pair_ctrl_ff[0];
      {2'b00, IDX_PAIR_TWO_CTRL}: rd_byte = pair_ctrl_ff[1];
      {2'b00, IDX_IN_A_LEFT}: rd_byte = {1'b0, in_gain_ff[0]};
      {2'b00, IDX_IN_A_RIGHT}: rd_byte = {1'b0, in_gain_ff[1]};
      {2'b00, IDX_IN_B_LEFT}: rd_byte = {1'b0, in_gain_ff[2]};
      {2'b00, IDX_IN_B_RIGHT}: rd_byte = {1'b0, in_gain_ff[3]};
      {2'b00, IDX_OUT_A_LEFT}: rd_byte = out_gain_ff[0];
      {2'b00, IDX_OUT_A_RIGHT}: rd_byte = out_gain_ff[1];
      default: rd_byte = 8'h00;
    endcase
  end

  // read data and error captured in the setup phase, shown in access phase
  always_ff @(posedge ref_clk_i or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
    end else if (psel_i && !penable_i) begin
      rdata_ff <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      err_ff <= !hit_any;
    end
  end

  assign pready_o = 1'b1;
  assign prdata_o = rd_en ? rdata_ff : 32'h0000_0000;
  assign pslverr_o = psel_i && penable_i && err_ff;

  // gains to the signal path
  assign gain_o.in_a_left = in_gain_ff[0];
  assign gain_o.in_a_right = in_gain_ff[1];
  assign gain_o.in_b_left = in_gain_ff[2];
  assign gain_o.in_b_right = in_gain_ff[3];
  assign gain_o.out_a_left = out_gain_ff[0];
  assign gain_o.out_a_right = out_gain_ff[1];
endmodule : pmg_top
`default_nettype wire

// ---- shared/pmg_pkg.sv ----
package pmg_pkg;
  // register indices; offsets are all multiples of four, byte address = 4 * index
  localparam logic [7:0] IDX_PAIR_ONE_CTRL = 8'hF0;
  localparam logic [7:0] IDX_PAIR_TWO_CTRL = 8'hF1;
  localparam logic [7:0] IDX_IN_A_LEFT = 8'hF4;
  localparam logic [7:0] IDX_IN_A_RIGHT = 8'hF5;
  localparam logic [7:0] IDX_IN_B_LEFT = 8'hF6;
  localparam logic [7:0] IDX_IN_B_RIGHT = 8'hF7;
  localparam logic [7:0] IDX_OUT_A_LEFT = 8'hF8;
  localparam logic [7:0] IDX_OUT_A_RIGHT = 8'hF9;
  localparam int ADDR_LSB = 2;
  // control field positions
  localparam int BIT_RIGHT_EN = 7;
  localparam int BIT_LEFT_EN = 6;
  localparam int BIT_CLK_RATE = 2;
  localparam int BIT_SAMPLE_PHASE = 1;
  localparam int BIT_DATA_SEL = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hC7;
  localparam logic [7:0] IN_GAIN_WMASK = 8'h7F;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [6:0] IN_GAIN_RESET = 7'h6F;
  localparam logic [7:0] OUT_GAIN_RESET = 8'h6F;
  // microphone clock dividers: last count of a half period, one less than its length in system clocks
  localparam logic [1:0] HALF_DIV4 = 2'h1;
  localparam logic [1:0] HALF_DIV8 = 2'h3;
  // decoded control of one microphone interface
  typedef struct packed {
    logic right_en;
    logic left_en;
    logic clk_rate;
    logic sample_phase;
    logic data_sel;
  } pmg_ctrl_s;
  // one captured sample from a microphone interface
  typedef struct packed {
    logic left_valid;
    logic right_valid;
    logic data;
  } pmg_sample_s;
  // gain settings handed to the signal path
  typedef struct packed {
    logic [6:0] in_a_left;
    logic [6:0] in_a_right;
    logic [6:0] in_b_left;
    logic [6:0] in_b_right;
    logic [7:0] out_a_left;
    logic [7:0] out_a_right;
  } pmg_gain_s;
endpackage : pmg_pkg

// ---- tb/pmg_mic_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// two microphones sharing one data line
module pmg_mic_model (
  input wire logic sys_clk_i,
  input wire logic mic_clk_i,
  input wire logic swap_i, // 1: left microphone drives while the clock is low
  input wire logic [1:0] bits_i, // {right, left} levels
  output logic data_o
);
  logic [3:0] idle_ff = 4'hF;
  logic last_ff = 1'b0;
  logic drive;
  // one microphone per clock level
  assign drive = (mic_clk_i ^ swap_i) ? bits_i[0] : bits_i[1];
  always_ff @(posedge sys_clk_i) begin
    idle_ff <= mic_clk_i ? 4'h0 : idle_ff + {3'h0, idle_ff != 4'hF};
    last_ff <= (idle_ff < 4'h9) ? drive : last_ff;
  end
  // released line shows the inverse of its last level
  // a high clock wakes the microphones at once
  assign data_o = (idle_ff > 4'h8 && !mic_clk_i) ? ~last_ff : drive;
endmodule : pmg_mic_model
`default_nettype wire

// ---- tb/pmg_top_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module pmg_top_chk (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic [1:0] pdm_mic_clock_pin_o,
  input wire pmg_pkg::pmg_sample_s [1:0] mic_sample_o,
  input wire pmg_pkg::pmg_gain_s gain_o
);
  import pmg_pkg::*;
  logic [7:0] ctl_ff;
  wire logic acc = psel_i & penable_i;
  wire logic wr_ok = acc & pwrite_i & pstrb_i[0];
  wire logic [9:0] idx = paddr_i[11:2];
  wire logic mck = pdm_mic_clock_pin_o[0];
  // shadow of the first interface control
  always_ff @(posedge ref_clk_i or negedge resetn_i)
    if (!resetn_i) ctl_ff <= 8'h00;
    else if (wr_ok && idx == 10'h0F0) ctl_ff <= pwdata_i[7:0];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  chk_in_a_gain: assert property (wr_ok && idx == 10'h0F4
    |=> gain_o.in_a_left == $past(pwdata_i[6:0])) else $error("input a left gain wrong");
  chk_in_width: assert property (acc && !pwrite_i && idx == 10'h0F4
    |-> prdata_o[31:7] == 25'h0) else $error("input gain reads too wide");
  chk_out_gain: assert property (wr_ok && idx == 10'h0F9
    |=> gain_o.out_a_right == $past(pwdata_i[7:0])) else $error("output gain wrong");
  chk_in_b_gain: assert property (wr_ok && idx == 10'h0F7
    |=> gain_o.in_b_right == $past(pwdata_i[6:0])) else $error("input b right gain wrong");
  chk_right_off: assert property ((!ctl_ff[7])[*8]
    |-> !mic_sample_o[0].right_valid) else $error("right sample while disabled");
  chk_left_off: assert property ((!ctl_ff[6])[*8]
    |-> !mic_sample_o[0].left_valid) else $error("left sample while disabled");
  chk_div_four: assert property ($rose(mck) && !ctl_ff[2]
    |-> ##1 mck ##1 !mck[*2]) else $error("clock not divided by four");
  chk_div_eight: assert property ($rose(mck) && ctl_ff[2]
    |-> mck[*4] ##1 !mck[*4]) else $error("clock not divided by eight");
  chk_clock_idle: assert property ((!ctl_ff[7] && !ctl_ff[6])[*8]
    |-> !mck) else $error("clock runs while idle");
  chk_clock_start: assert property ($rose(ctl_ff[7] | ctl_ff[6])
    |-> ##[0:2] mck) else $error("clock did not start");
endmodule : pmg_top_chk
bind pmg_top pmg_top_chk u_chk (.ref_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pdm_mic_clock_pin_o, .mic_sample_o, .gain_o);
`default_nettype wire

// ---- tb/test_pdm_mic_input_and_gain.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_pdm_mic_input_and_gain;
  import pmg_pkg::*;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd, q;
  logic prdy, perr, e;
  logic [1:0] md, mc, mcq;
  logic [1:0] sw = 2'h0;
  pmg_sample_s [1:0] smp;
  pmg_gain_s gn;
  logic [7:0] cfg;
  logic [7:0] mode[7] = '{8'hC0, 8'hC3, 8'hC5, 8'hC6, 8'h40, 8'h80, 8'hFF};
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int nl[2], nr[2], nk[2];
  always #5 ref_clk_i = ~ref_clk_i;
  pmg_top uut (.ref_clk_i, .resetn_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(4'hF), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .pdm_mic_data_i(md), .pdm_mic_clock_pin_o(mc), .mic_sample_o(smp),
    .gain_o(gn));
  for (genvar i = 0; i < 2; i++) begin : g_mic
    pmg_mic_model mic (.sys_clk_i(ref_clk_i), .mic_clk_i(mc[i]), .swap_i(sw[i]),
      .bits_i({i == 1, i == 0}), .data_o(md[i]));
  end
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string w, input logic [43:0] got, input logic [43:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", w, exp, got);
    end
  endtask : chk
  // watchdog, sample monitor and clock edge counter
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc > 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
    for (int i = 0; i < 2; i++) begin
      if (mc[i] === 1'b1 && mcq[i] === 1'b0) nk[i]++;
      if (smp[i].left_valid === 1'b1) begin
        nl[i]++;
        chk("left data", {43'h0, smp[i].data}, {43'h0, i == 0});
      end
      if (smp[i].right_valid === 1'b1) begin
        nr[i]++;
        chk("right data", {43'h0, smp[i].data}, {43'h0, i == 1});
      end
    end
    mcq = mc;
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge ref_clk_i);
    pen <= 1'b1;
    do @(posedge ref_clk_i); while (prdy !== 1'b1);
    q = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge ref_clk_i);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk("read data", {12'h0, q}, {12'h0, x});
    chk("error flag", {43'h0, e}, {43'h0, xe});
  endtask : rd
  function automatic logic [11:0] adr(input int i);
    return 12'h3C0 + 12'(4 * i + (i < 2 ? 0 : 8));
  endfunction : adr
  initial begin
    repeat (12) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk("gains", gn, {{4{7'h6F}}, {2{8'h6F}}});
    for (int i = 0; i < 8; i++) rd(adr(i), i < 2 ? 32'h0 : 32'h6F, 1'b0);
    rd(12'h3C8, 32'h0, 1'b1);
    $display("reset values done");
    for (int i = 2; i < 8; i++) apb(1'b1, adr(i), 32'hFFFFFFFF - 32'(i - 2));
    for (int i = 2; i < 8; i++) rd(adr(i), (i < 6 ? 32'h81 : 32'h101) - 32'(i), 1'b0);
    chk("gains", gn, {7'h7F, 7'h7E, 7'h7D, 7'h7C, 8'hFB, 8'hFA});
    $display("gain access done");
    foreach (mode[k]) begin
      cfg = mode[k];
      // edge captures see the level before the edge, mid-half captures the level after it
      sw <= {cfg[0] ^ cfg[1], ~(cfg[0] ^ cfg[1])};
      apb(1'b1, 12'h3C0, {24'h0, cfg});
      apb(1'b1, 12'h3C4, {24'h0, cfg ^ 8'h05});
      nl = '{0, 0};
      nr = '{0, 0};
      nk = '{0, 0};
      repeat (64) @(posedge ref_clk_i);
      rd(12'h3C0, {24'h0, cfg & 8'hC7}, 1'b0);
      chk("captures", {39'h0, nl[0] > 0, nr[0] > 0, nl[1] > 0, nr[1] > 0, nk[1] > 11},
        {39'h0, cfg[6], cfg[7], cfg[6], cfg[7], cfg[2]});
      // clear the enables only, so the clock winds down at its own rate
      apb(1'b1, 12'h3C0, {24'h0, cfg & 8'h07});
      apb(1'b1, 12'h3C4, {24'h0, (cfg ^ 8'h05) & 8'h07});
      repeat (16) @(posedge ref_clk_i);
      chk("clocks idle", {42'h0, mc}, 44'h0);
      $display("mode %h done", cfg);
    end
    tally_and_finish();
  end
endmodule : test_pdm_mic_input_and_gain
`default_nettype wire
